// ==== shared/uoer_map.vh ====
/*
 Register map, field positions and timing counts of the USB event and
 configuration register block.
 Assumes inclusion by bare name from design files under hw/.
*/
`ifndef UOER_MAP_VH
`define UOER_MAP_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define UOER_ADDR_FLAGS     8'h00
`define UOER_ADDR_ENABLES   8'h04
`define UOER_ADDR_CONFIG    8'h08
`define UOER_ADDR_EVENTS    8'h0C
`define UOER_ADDR_STATUS    8'h10
`define UOER_ADDR_CONTROL   8'h14

// ----------------------------------------------------------------
// Event flag fields
// ----------------------------------------------------------------
`define UOER_FLG_ID         7
`define UOER_FLG_MS         6
`define UOER_FLG_LINE       5
`define UOER_FLG_ACT        4
`define UOER_FLG_SDROP      3
`define UOER_FLG_SEND       2
`define UOER_FLG_SVALID     0
`define UOER_FLG_MASK       8'hFD

// ----------------------------------------------------------------
// Configuration fields
// ----------------------------------------------------------------
`define UOER_CFG_EYE        7
`define UOER_CFG_OEMON      6
`define UOER_CFG_SIDL       4
`define UOER_CFG_ASUSP      0
`define UOER_CFG_MASK       8'hD1

// Control register: bit 0 manual suspend, bit 1 host mode
`define UOER_CTL_SUSP       0
`define UOER_CTL_HOST       1
`define UOER_CTL_MASK       8'h03

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define UOER_RST_REG        8'h00
`define UOER_MS_NS          1000000
`define UOER_CLK_NS         8
`define UOER_MS_CYCLES      (`UOER_MS_NS / `UOER_CLK_NS)

`endif

// ==== hw/uoer_sync.v ====
/*
 Three-stage input synchroniser with agreement filter.
 Assumes an asynchronous input and one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module uoer_sync #(
	parameter WIDTH = 1
) (
	// Clock and reset
	input  wire             hclk,
	input  wire             hresetn,
	input  wire             clk_en,
	// Data
	input  wire [WIDTH-1:0] async_in,
	output reg  [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] stage1;
	reg [WIDTH-1:0] stage2;
	reg [WIDTH-1:0] stage3;

	// Output follows only once second and third stages agree
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stage1   <= {WIDTH{1'b0}};
			stage2   <= {WIDTH{1'b0}};
			stage3   <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end else if (clk_en) begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
			sync_out <= (stage2 & stage3) | (sync_out & (stage2 | stage3));
		end
	end

endmodule

`default_nettype wire

// ==== hw/uoer_top.v ====
/*
 USB On-The-Go event flags, event enables and configuration registers
 behind an AHB-Lite slave.
 Registers: OTG flags, event enables, configuration, core events,
 synchronised pin status and a control word.
 Assumes pin inputs asynchronous to hclk; event pulses from the USB
 core are synchronous to hclk. Only single whole-word transfers are
 decoded; hsize is not looked at.
*/
`timescale 1ns/1ps
`default_nettype none
`include "uoer_map.vh"

// Operation
// - One register gathers all On-The-Go status-change flags as separate bits.
// - Flags set by hardware, cleared only by software writing one.
// - Bit 7 sets on any change of the identification input.
// - Bit 6 sets each time the one-millisecond timer expires.
// - Bit 5 sets when line state stable one millisecond at new value.
// - Bit 4 sets when pin activity wakes the device.
// - Bit 3 sets when VBUS falls below session end level.
// - Bit 2 sets on any change of the session end comparator.
// - Bit 0 sets on session valid change; bit 1 unimplemented.
// - Bits 31 to 8 read as zero.
// - Enables: stall bit 7, attach 6, resume 5, idle 4.
// - Bit 3 gates token done, bit 2 gates frame start.
// - Bit 0 enables bus reset as peripheral, detach as host.
// - Config bit 7 drives eye-pattern test enable.
// - Config bit 6 enables drive monitor output while lines driven.
// - Config bit 4 halts module in Idle mode.
// - Config bit 0 suspends module automatically on Sleep.
module uoer_top #(
	parameter MS_CYCLES = `UOER_MS_CYCLES
) (
	// Clock, reset and enable
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        clk_en,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	// Pins from the transceiver
	input  wire        id_pin,
	input  wire        dp_pin,
	input  wire        dm_pin,
	input  wire        vbus_pin,
	input  wire        sess_end_in,
	input  wire        sess_valid_in,
	input  wire        lines_driven,
	// Core events, one-cycle pulses
	input  wire        stall_evt,
	input  wire        attach_evt,
	input  wire        resume_evt,
	input  wire        idle_evt,
	input  wire        token_done_evt,
	input  wire        frame_start_evt,
	input  wire        error_evt,
	input  wire        bus_reset_evt,
	input  wire        detach_evt,
	// Power mode of the device
	input  wire        idle_mode,
	input  wire        sleep_mode,
	input  wire        module_asleep,
	// Outputs
	output reg         combined_usb_irq,
	output reg         eye_test_enable,
	output reg         drive_monitor,
	output reg         module_halt,
	output reg         module_suspend
);

	// ----------------------------------------------------------------
	// Input synchronisation
	// ----------------------------------------------------------------
	// One synchroniser for all pins; bit order matches the status register
	wire [6:0] pins_s;

	uoer_sync #(
		.WIDTH(7)
	) u_sync (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.clk_en   (clk_en),
		.async_in ({lines_driven, sess_valid_in, sess_end_in,
		            vbus_pin, dm_pin, dp_pin, id_pin}),
		.sync_out (pins_s)
	);

	wire id_s     = pins_s[0];
	wire dp_s     = pins_s[1];
	wire dm_s     = pins_s[2];
	wire vbus_s   = pins_s[3];
	wire send_s   = pins_s[4];
	wire svalid_s = pins_s[5];
	wire drive_s  = pins_s[6];

	// ----------------------------------------------------------------
	// Pin history for change detection
	// ----------------------------------------------------------------
	// Bit order follows the status register: id, dp, dm, vbus, send
	reg  [4:0] prev_pins;
	reg        prev_svalid;

	wire [4:0] pins_now = {send_s, vbus_s, dm_s, dp_s, id_s};

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev_pins   <= 5'h00;
			prev_svalid <= 1'b0;
		end else if (clk_en) begin
			prev_pins   <= pins_now;
			prev_svalid <= svalid_s;
		end
	end

	// ----------------------------------------------------------------
	// Millisecond timer and line state filter
	// ----------------------------------------------------------------
	reg [31:0] ms_count;
	reg        ms_tick;
	reg [1:0]  line_prev;
	reg [1:0]  line_last;
	reg [31:0] line_count;
	reg        line_armed;
	reg        line_evt;

	wire [1:0] line_now = {dm_s, dp_s};

	// Shared by the timer and the line filter so both use one period
	function uoer_expired;
		input [31:0] count;
		begin
			uoer_expired = count >= MS_CYCLES - 1;
		end
	endfunction

	// The line filter restarts on every change, so chattering lines never
	// report; a level that settles at a new value reports once, one period later.

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ms_count   <= 32'h00000000;
			ms_tick    <= 1'b0;
			line_prev  <= 2'h0;
			line_last  <= 2'h0;
			line_count <= 32'h00000000;
			line_armed <= 1'b0;
			line_evt   <= 1'b0;
		end else if (clk_en) begin
			ms_tick  <= 1'b0;
			line_evt <= 1'b0;
			if (uoer_expired(ms_count)) begin
				ms_count <= 32'h00000000;
				ms_tick  <= 1'b1;
			end else begin
				ms_count <= ms_count + 32'h00000001;
			end
			line_prev <= line_now;
			// Restart the stability window on every change
			if (line_now != line_prev) begin
				line_count <= 32'h00000000;
				line_armed <= 1'b1;
			end else if (line_armed) begin
				if (uoer_expired(line_count)) begin
					line_armed <= 1'b0;
					if (line_now != line_last) begin
						line_evt  <= 1'b1;
						line_last <= line_now;
					end
				end else begin
					line_count <= line_count + 32'h00000001;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Event sources of the flag register
	// ----------------------------------------------------------------
	reg [7:0] flag_set;

	always @* begin
		flag_set = 8'h00;
		flag_set[`UOER_FLG_ID]     = id_s != prev_pins[0];
		flag_set[`UOER_FLG_MS]     = ms_tick;
		flag_set[`UOER_FLG_LINE]   = line_evt;
		// Wake only counts while the module sleeps
		flag_set[`UOER_FLG_ACT]    = module_asleep &&
			(prev_pins != pins_now);
		flag_set[`UOER_FLG_SDROP]  = send_s && !prev_pins[4];
		flag_set[`UOER_FLG_SEND]   = send_s != prev_pins[4];
		flag_set[`UOER_FLG_SVALID] = svalid_s != prev_svalid;
	end

	// ----------------------------------------------------------------
	// AHB-Lite slave
	// ----------------------------------------------------------------
	reg        dp_write;
	reg [7:0]  dp_addr;
	reg [7:0]  otg_event_flags;
	reg [7:0]  usb_event_enables;
	reg [7:0]  usb_config_one;
	reg [8:0]  usb_events;
	reg [7:0]  control;
	reg [7:0]  next_flags;
	reg [8:0]  next_events;

	wire take = hsel && hready && htrans[1] && clk_en;

	function [31:0] uoer_read;
		input [7:0] addr;
		begin
			if (addr == `UOER_ADDR_FLAGS)
				uoer_read = {24'h000000, otg_event_flags};
			else if (addr == `UOER_ADDR_ENABLES)
				uoer_read = {24'h000000, usb_event_enables};
			else if (addr == `UOER_ADDR_CONFIG)
				uoer_read = {24'h000000, usb_config_one};
			else if (addr == `UOER_ADDR_EVENTS)
				uoer_read = {23'h000000, usb_events};
			else if (addr == `UOER_ADDR_STATUS)
				uoer_read = {25'h0000000, pins_s};
			else if (addr == `UOER_ADDR_CONTROL)
				uoer_read = {24'h000000, control};
			else
				uoer_read = 32'h00000000;
		end
	endfunction

	// Write strobes of the data phase, one per writable register
	wire       wr_flags   = dp_write && dp_addr == `UOER_ADDR_FLAGS;
	wire       wr_enables = dp_write && dp_addr == `UOER_ADDR_ENABLES;
	wire       wr_config  = dp_write && dp_addr == `UOER_ADDR_CONFIG;
	wire       wr_evts    = dp_write && dp_addr == `UOER_ADDR_EVENTS;
	wire       wr_control = dp_write && dp_addr == `UOER_ADDR_CONTROL;
	wire [7:0] wmask      = hwdata[7:0];

	// Core events: bit 8 error, bit 0 bus reset or detach
	wire [8:0] evt_in = {error_evt, stall_evt, attach_evt, resume_evt,
		idle_evt, token_done_evt, frame_start_evt, 1'b0,
		control[`UOER_CTL_HOST] ? detach_evt : bus_reset_evt};

	// Bus side: capture the address phase, answer reads in the data phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			dp_write  <= 1'b0;
			dp_addr   <= 8'h00;
		end else if (clk_en) begin
			dp_write <= take && hwrite;
			if (take)
				dp_addr <= {haddr[7:2], 2'b00};
			if (take && !hwrite)
				hrdata <= uoer_read({haddr[7:2], 2'b00});
		end
	end

	// ----------------------------------------------------------------
	// Flag registers
	// ----------------------------------------------------------------
	// Set wins over a simultaneous write-one clear, so no event is lost
	always @* begin
		next_flags  = otg_event_flags;
		next_events = usb_events;
		if (wr_flags)
			next_flags = next_flags & ~wmask;
		if (wr_evts)
			next_events = next_events & ~hwdata[8:0];
		next_flags  = (next_flags | flag_set) & `UOER_FLG_MASK;
		next_events = next_events | evt_in;
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			otg_event_flags <= `UOER_RST_REG;
			usb_events      <= 9'h000;
		end else if (clk_en) begin
			otg_event_flags <= next_flags;
			usb_events      <= next_events;
		end
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			usb_event_enables <= `UOER_RST_REG;
			usb_config_one    <= `UOER_RST_REG;
			control           <= `UOER_RST_REG;
		end else if (clk_en) begin
			if (wr_enables)
				usb_event_enables <= wmask;
			if (wr_config)
				usb_config_one <= wmask & `UOER_CFG_MASK;
			if (wr_control)
				control <= wmask & `UOER_CTL_MASK;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt combine and configuration outputs
	// ----------------------------------------------------------------
	// Error events have their own gate in bit 1, which no core event uses
	wire [7:0] core_gated = usb_events[7:0] & usb_event_enables;
	wire       error_hit  = usb_events[8] && usb_event_enables[1];
	wire       core_hit   = |core_gated || error_hit;
	// There is no enable register for the flags: any flag raises the irq
	wire       otg_hit    = |otg_event_flags;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			combined_usb_irq <= 1'b0;
			eye_test_enable  <= 1'b0;
			drive_monitor    <= 1'b0;
			module_halt      <= 1'b0;
			module_suspend   <= 1'b0;
		end else if (clk_en) begin
			// Registered, so each output follows its source a cycle late
			combined_usb_irq <= core_hit || otg_hit;
			eye_test_enable  <= usb_config_one[`UOER_CFG_EYE];
			drive_monitor    <= usb_config_one[`UOER_CFG_OEMON] &&
				drive_s;
			module_halt      <= usb_config_one[`UOER_CFG_SIDL] &&
				idle_mode;
			module_suspend   <= control[`UOER_CTL_SUSP] ||
				(usb_config_one[`UOER_CFG_ASUSP] && sleep_mode);
		end
	end

endmodule

`default_nettype wire

// ==== verification/uoer_top_monitor.sv ====
/*
 Port checker for uoer_top, bound into every instance.
 Assumes clk_en high during reads and hready tied to hreadyout.
*/
`timescale 1ns/1ps
`default_nettype none
module uoer_top_monitor (
	// Clock and bus
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hrdata,
	// Pins and power modes
	input wire logic        id_pin,
	input wire logic        lines_driven,
	input wire logic        idle_mode,
	input wire logic        sleep_mode,
	// Outputs
	input wire logic        combined_usb_irq,
	input wire logic        eye_test_enable,
	input wire logic        drive_monitor,
	input wire logic        module_halt,
	input wire logic        module_suspend
);
default clocking @(posedge hclk); endclocking
default disable iff (!hresetn);
logic       rd;
logic [7:0] rd_a;
// Marks the data phase of a read and where it points
always_ff @(posedge hclk or negedge hresetn) begin
	if (!hresetn)
		rd <= 1'b0;
	else
		rd <= hsel && htrans[1] && !hwrite;
end
always_ff @(posedge hclk) begin
	rd_a <= haddr[7:0];
end
AST_FLAG_RSVD: assert property (rd && rd_a == 8'h00 |-> !hrdata[1])
	else $error("flag bit 1 reads set");
AST_HIGH_ZERO: assert property (rd |-> hrdata[31:9] == 23'h0)
	else $error("upper read bits not zero");
AST_ENA_RSVD: assert property (rd && rd_a == 8'h04 |-> hrdata[31:8] == 24'h0)
	else $error("enable register upper bits set");
AST_CFG_EYE: assert property (rd && rd_a == 8'h08 |->
	hrdata[7] == eye_test_enable && (hrdata & 32'hFFFFFF2E) == 32'h0)
	else $error("eye test output differs from config");
// Sync chain plus output register needs several quiet cycles
AST_DRIVE_OFF: assert property (!lines_driven[*7] |-> !drive_monitor)
	else $error("drive monitor active with lines idle");
AST_HALT: assert property (!idle_mode[*2] |-> !module_halt)
	else $error("halt outside idle mode");
AST_SUSPEND: assert property (rd && rd_a == 8'h08 && hrdata[0] &&
	$past(sleep_mode) |-> module_suspend)
	else $error("no suspend in sleep with auto suspend");
AST_ID_IRQ: assert property ($changed(id_pin) ##1
	$stable(id_pin)[*8] |=> combined_usb_irq)
	else $error("id change raised no interrupt");
CVR_CFG_READ: cover property (rd && rd_a == 8'h08);
CVR_SUSPEND: cover property (module_suspend);
CVR_IRQ_DROP: cover property (combined_usb_irq ##1 !combined_usb_irq);
endmodule
bind uoer_top uoer_top_monitor uoer_top_monitor_i (.*);
`default_nettype wire

// ==== verification/uoer_far_end.sv ====
/*
 Far-end model: transceiver lines and comparators seen by the block.
 Assumes the caller sits just after a rising hclk edge.
*/
`timescale 1ns/1ps
`default_nettype none
module uoer_far_end (
	// Clock
	input wire logic hclk,
	// Lines toward the block
	output logic     id_pin,
	output logic     dp_pin,
	output logic     dm_pin,
	output logic     vbus_pin,
	output logic     sess_end_in,
	output logic     sess_valid_in,
	output logic     lines_driven
);
logic [6:0] pins = 7'h00;
assign {lines_driven, sess_valid_in, sess_end_in, vbus_pin} = pins[6:3];
assign {dm_pin, dp_pin, id_pin} = pins[2:0];
// A lag of some cycles models a slow remote party
task automatic put(input int idx, input logic v, input int lag);
	repeat (lag) @(posedge hclk);
	pins[idx] <= v;
endtask
endmodule
`default_nettype wire

// ==== verification/uoer_top_tb_top.sv ====
/*
 Self-checking bench for uoer_top over AHB-Lite with a far-end model.
 Assumes the register offsets of the map header; shortened ms count.
*/
`timescale 1ns/1ps
`default_nettype none
module uoer_top_tb_top;
localparam int MS = 400;
logic        hclk = 1'b0;
logic        hresetn = 1'b0;
logic        clk_en = 1'b1;
logic        hsel = 1'b0;
logic [31:0] haddr = 32'h0;
logic [1:0]  htrans = 2'b00;
logic        hwrite = 1'b0;
logic [2:0]  hsize = 3'b010;
logic [31:0] hwdata = 32'h0;
wire logic   hready, hreadyout, hresp;
wire logic [31:0] hrdata;
wire logic   id_pin, dp_pin, dm_pin, vbus_pin;
wire logic   sess_end_in, sess_valid_in, lines_driven;
logic [8:0]  ev = 9'h000;
wire logic   bus_reset_evt, detach_evt, frame_start_evt, token_done_evt;
wire logic   idle_evt, resume_evt, attach_evt, stall_evt, error_evt;
logic        idle_mode = 1'b0;
logic        sleep_mode = 1'b0;
logic        module_asleep = 1'b0;
wire logic   combined_usb_irq, eye_test_enable, drive_monitor;
wire logic   module_halt, module_suspend;
logic [31:0] q;
int          num_errors = 0;
int          n_compared = 0;
int          d, k;
int          pidx[5] = '{0, 5, 4, 3, 1};
int          pexp[5] = '{32'h80, 32'h01, 32'h0C, 32'h10, 32'h20};
int          pos[9] = '{0, 0, 2, 3, 4, 5, 6, 7, 8};
assign hready = hreadyout;
assign {error_evt, stall_evt, attach_evt, resume_evt, idle_evt} = ev[8:4];
assign {token_done_evt, frame_start_evt, detach_evt, bus_reset_evt} = ev[3:0];
always #4 hclk = ~hclk;
uoer_top #(.MS_CYCLES(MS)) uoer_top_i (.*);
uoer_far_end uoer_far_end_i (.*);
task automatic chk(input string nm, input logic [31:0] e, g);
	n_compared++;
	if (g !== e) begin
		num_errors++;
		$display("wrong value %s expected %h seen %h", nm, e, g);
	end
endtask
task automatic hwait();
	do
		@(posedge hclk);
	while (hready !== 1'b1);
endtask
task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
	hsel <= 1'b1;
	htrans <= 2'b10;
	hwrite <= w;
	haddr <= {24'h0, a};
	hwait();
	hsel <= 1'b0;
	htrans <= 2'b00;
	hwdata <= v;
	hwait();
	q = hrdata;
endtask
task automatic rc(input logic [7:0] a, input logic [31:0] e, m);
	bus(1'b0, a, 32'h0);
	chk($sformatf("reg %h", a), e & m, q & m);
endtask
task automatic conclude();
	$display("compared %0d mismatches %0d", n_compared, num_errors);
	if (num_errors == 0 && n_compared > 0)
		$display("Result: passed");
	else
		$display("Result: failed");
	$finish;
endtask
initial begin
	repeat (20000) @(posedge hclk);
	num_errors++;
	conclude();
end
initial begin
	d = $urandom(32'h9C49DEF2);
	repeat (12) @(posedge hclk);
	hresetn <= 1'b1;
	@(posedge hclk);
	// Timer flag masked: it may expire at any time
	for (k = 0; k <= 32'h20; k += 4)
		rc(k[7:0], 32'h0, 32'hFFFFFFBF);
	$display("test reset done");
	repeat (4) begin
		d = $urandom;
		bus(1'b1, 8'h04, d);
		bus(1'b1, 8'h08, d);
		rc(8'h04, d & 32'hFF, 32'hFFFFFFFF);
		rc(8'h08, d & 32'hD1, 32'hFFFFFFFF);
		chk("eye", d[7], eye_test_enable);
	end
	$display("test rw done");
	foreach (pidx[i]) begin
		module_asleep <= (i == 3);
		bus(1'b1, 8'h00, 32'hFF);
		uoer_far_end_i.put(pidx[i], 1'b1, i);
		repeat (i == 4 ? MS + 20 : 15) @(posedge hclk);
		rc(8'h00, pexp[i], 32'hBF);
		bus(1'b1, 8'h00, 32'h0);
		rc(8'h00, pexp[i], 32'hBF);
		bus(1'b1, 8'h00, pexp[i]);
		rc(8'h00, 32'h0, 32'hBF);
	end
	$display("test pin flags done");
	bus(1'b1, 8'h00, 32'hFF);
	k = 0;
	do begin
		bus(1'b0, 8'h00, 32'h0);
		k++;
	end while (q[6] !== 1'b1 && k < 600);
	chk("timer", 32'h1, q[6]);
	// Cleared a few cycles after expiry, leaving nearly a full period free of it
	bus(1'b1, 8'h00, 32'h40);
	$display("test timer done");
	for (int i = 0; i < 9; i++) begin
		bus(1'b1, 8'h14, i == 1 ? 32'h2 : 32'h0);
		bus(1'b1, 8'h04, 32'h0);
		ev[i] <= 1'b1;
		@(posedge hclk);
		ev <= 9'h000;
		repeat (3) @(posedge hclk);
		chk("irq masked", 32'h0, combined_usb_irq);
		rc(8'h0C, 1 << pos[i], 32'hFFFFFFFF);
		bus(1'b1, 8'h04, 1 << (i == 8 ? 1 : pos[i]));
		repeat (3) @(posedge hclk);
		chk("irq enabled", 32'h1, combined_usb_irq);
		bus(1'b1, 8'h0C, 1 << pos[i]);
		repeat (3) @(posedge hclk);
		chk("irq cleared", 32'h0, combined_usb_irq);
	end
	$display("test events done");
	bus(1'b1, 8'h08, 32'h10);
	idle_mode <= 1'b1;
	repeat (3) @(posedge hclk);
	chk("halt", 32'h1, module_halt);
	bus(1'b1, 8'h08, 32'h01);
	idle_mode <= 1'b0;
	sleep_mode <= 1'b1;
	repeat (3) @(posedge hclk);
	chk("halt", 32'h0, module_halt);
	chk("suspend", 32'h1, module_suspend);
	rc(8'h08, 32'h01, 32'hFFFFFFFF);
	bus(1'b1, 8'h08, 32'h0);
	bus(1'b1, 8'h14, 32'h1);
	repeat (3) @(posedge hclk);
	chk("suspend", 32'h1, module_suspend);
	bus(1'b1, 8'h14, 32'h0);
	repeat (3) @(posedge hclk);
	chk("suspend", 32'h0, module_suspend);
	sleep_mode <= 1'b0;
	bus(1'b1, 8'h08, 32'h40);
	uoer_far_end_i.put(6, 1'b1, 2);
	repeat (9) @(posedge hclk);
	chk("monitor", 32'h1, drive_monitor);
	uoer_far_end_i.put(6, 1'b0, 0);
	repeat (9) @(posedge hclk);
	chk("monitor", 32'h0, drive_monitor);
	// A transfer made while the clock enable is low must leave no trace
	clk_en <= 1'b0;
	bus(1'b1, 8'h08, 32'h80);
	clk_en <= 1'b1;
	rc(8'h08, 32'h40, 32'hFFFFFFFF);
	chk("eye", 32'h0, eye_test_enable);
	$display("test power done");
	conclude();
end
endmodule
`default_nettype wire
